// File: core/dispatch_pkg.sv
package dispatch_pkg;

  localparam int VEC_W = 8;
  localparam int NUM_PREDEF = 18;
  localparam int NUM_USER = 224;
  localparam int NUM_LOW = 32;
  localparam int NUM_VEC = NUM_LOW + NUM_USER;
  localparam int GATE_W = 64;

  localparam logic [7:0] VEC_QUOTIENT = 8'h00;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_FIRST_USER = 8'h20;

  // Vectors that may be raised internally: 0-8, 10-14, 16-21
  localparam logic [31:0] PREDEF_MASK = 32'h003f7dff;
  localparam logic [31:0] TRAP_MASK = 32'h0000001a;
  localparam logic [31:0] ABORT_MASK = 32'h00040100;

  // Gate layout: offset, selector, access byte with type and present
  localparam int GATE_OFF_LSB = 0;
  localparam int GATE_SEL_LSB = 32;
  localparam int GATE_TYPE_LSB = 48;
  localparam int GATE_PRESENT_BIT = 55;
  localparam logic [3:0] GT_TASK = 4'h5;
  localparam logic [3:0] GT_MASKABLE_REQUEST_PIN = 4'he;
  localparam logic [3:0] GT_TRAP = 4'hf;

  localparam int FLAGS_IF_BIT = 9;
  localparam logic [31:0] FLAGS_RESET = 32'h00000002;

  typedef enum logic [1:0] {
    CLS_MASKABLE_REQUEST_PIN = 2'h0,
    CLS_FAULT = 2'h1,
    CLS_TRAP = 2'h2,
    CLS_ABORT = 2'h3
  } event_class_t;

  function automatic event_class_t class_of(input logic [7:0] v,
                                            input logic ext);
    if (ext) return CLS_MASKABLE_REQUEST_PIN;
    if (v >= VEC_FIRST_USER) return CLS_TRAP;
    if (ABORT_MASK[v[4:0]]) return CLS_ABORT;
    if (TRAP_MASK[v[4:0]]) return CLS_TRAP;
    return CLS_FAULT;
  endfunction

endpackage

// File: core/gate_table.sv
module gate_table #(
  parameter int DEPTH = dispatch_pkg::NUM_VEC,
  parameter int WIDTH = dispatch_pkg::GATE_W,
  parameter int AW = dispatch_pkg::VEC_W
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_index,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_index,
  output logic [WIDTH-1:0] rd_data_reg
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_index] <= wr_data;
    end
  end

  // Read data is held until the next read so the gate stays stable
  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data_reg <= mem[rd_index];
    end
  end
endmodule

// File: core/event_select.sv
module event_select #(
  parameter int W = dispatch_pkg::NUM_LOW,
  parameter int IW = 5
) (
  input wire logic [W-1:0] req,
  input wire logic [W-1:0] mask,
  output logic found,
  output logic [IW-1:0] index
);
  logic [W-1:0] hit;
  logic [W-1:0] below;
  logic [W-1:0] first;

  assign below[0] = 1'b0;
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    assign hit[i] = req[i] & mask[i];
    if (i > 0) begin : g_chain
      assign below[i] = below[i-1] | hit[i-1];
    end
    assign first[i] = hit[i] & ~below[i];
  end

  assign found = |hit;

  always_comb begin
    index = '0;
    for (int k = 0; k < W; k++) begin
      if (first[k]) begin
        index = index | IW'(k);
      end
    end
  end
endmodule

// File: core/interrupt_exception_dispatch.sv
module interrupt_exception_dispatch (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic quotient_fault_req,
  input wire logic debug_event_req,
  input wire logic breakpoint_trap_req,
  input wire logic overflow_trap_req,
  input wire logic bound_range_fault_req,
  input wire logic invalid_opcode_req,
  input wire logic fp_or_wait_op,
  input wire logic math_unit_absent,
  input wire logic invalid_task_state_req,
  input wire logic segment_not_present_req,
  input wire logic stack_fault_req,
  input wire logic general_protection_req,
  input wire logic page_fault_req,
  input wire logic math_fault_req,
  input wire logic alignment_check_req,
  input wire logic machine_check_req,
  input wire logic vector_fp_exception_req,
  input wire logic virtualization_exception_req,
  input wire logic checked_return_fail,
  input wire logic branch_tracking_en,
  input wire logic indirect_target,
  input wire logic target_is_marker,
  input wire logic nmi_req,
  input wire logic maskable_request_pin,
  input wire logic [7:0] maskable_vector,
  input wire logic swint_req,
  input wire logic [7:0] swint_vector,
  input wire logic [15:0] cur_cs,
  input wire logic [31:0] cur_ip,
  input wire logic [31:0] next_ip,
  input wire logic push_fault,
  input wire logic flags_load,
  input wire logic [31:0] flags_load_data,
  input wire logic interrupt_return_op_req,
  input wire logic [15:0] interrupt_return_op_cs,
  input wire logic [31:0] interrupt_return_op_ip,
  input wire logic [31:0] interrupt_return_op_flags,
  input wire logic gate_wr_en,
  input wire logic [7:0] gate_wr_index,
  input wire logic [63:0] gate_wr_data,
  output logic event_ack,
  output logic flush_req,
  output logic busy,
  output logic [7:0] dispatch_vector,
  output dispatch_pkg::event_class_t dispatch_class,
  output logic push_valid,
  output logic [31:0] push_data,
  output logic branch_valid,
  output logic [15:0] branch_cs,
  output logic [31:0] branch_ip,
  output logic task_call_valid,
  output logic [15:0] task_selector,
  output logic [31:0] flags_word,
  output logic shutdown
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_READ = 8'h02,
    ST_PUSH_FLAGS = 8'h04,
    ST_PUSH_CS = 8'h08,
    ST_PUSH_IP = 8'h10,
    ST_BRANCH = 8'h20,
    ST_TASK = 8'h40,
    ST_HALT = 8'h80
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [31:0] cause;
  logic nm_cause;
  logic cp_cause;
  logic exc_found;
  logic [4:0] exc_index;
  logic take;
  logic take_ext;
  logic [7:0] take_vec;
  dispatch_pkg::event_class_t take_class;
  logic interrupt_return_op_take;
  logic escalate;
  logic rd_en;
  logic [7:0] rd_index;
  logic [63:0] gate_data;
  logic [3:0] gate_type;
  logic gate_bad;
  logic [15:0] saved_cs_reg;
  logic [31:0] saved_ip_reg;

  assign nm_cause = fp_or_wait_op & math_unit_absent;
  assign cp_cause = checked_return_fail |
    (branch_tracking_en & indirect_target & ~target_is_marker);

  // Bit position is the vector; reserved and internal-only slots stay 0
  assign cause = {10'h000,
    cp_cause,
    virtualization_exception_req, vector_fp_exception_req,
    machine_check_req,
    alignment_check_req,
    math_fault_req, 1'b0,
    page_fault_req, general_protection_req,
    stack_fault_req,
    segment_not_present_req,
    invalid_task_state_req,
    1'b0, 1'b0,
    nm_cause,
    invalid_opcode_req,
    bound_range_fault_req, overflow_trap_req, breakpoint_trap_req,
    1'b0, debug_event_req,
    quotient_fault_req};

  // Lowest set vector wins; mask keeps reserved vectors out
  event_select #(
    .W(dispatch_pkg::NUM_LOW),
    .IW(5)
  ) u_select (
    .req(cause),
    .mask(dispatch_pkg::PREDEF_MASK),
    .found(exc_found),
    .index(exc_index)
  );

  // Exceptions first, then software interrupt, then NMI, then pin
  always_comb begin
    take = 1'b0;
    take_ext = 1'b0;
    take_vec = 8'h00;
    if (exc_found) begin
      take = 1'b1;
      take_vec = {3'h0, exc_index};
    end else if (swint_req) begin
      take = 1'b1;
      take_vec = swint_vector;
    end else if (nmi_req) begin
      take = 1'b1;
      take_ext = 1'b1;
      take_vec = dispatch_pkg::VEC_NMI;
    end else if (maskable_request_pin &&
                 flags_word[dispatch_pkg::FLAGS_IF_BIT] &&
                 maskable_vector >= dispatch_pkg::VEC_FIRST_USER) begin
      take = 1'b1;
      take_ext = 1'b1;
      take_vec = maskable_vector;
    end
  end

  assign take_class = dispatch_pkg::class_of(take_vec, take_ext);
  assign interrupt_return_op_take = (state_reg == ST_IDLE) && !take && interrupt_return_op_req;

  gate_table #(
    .DEPTH(dispatch_pkg::NUM_VEC),
    .WIDTH(dispatch_pkg::GATE_W),
    .AW(dispatch_pkg::VEC_W)
  ) u_table (
    .ref_clk(ref_clk),
    .wr_en(gate_wr_en),
    .wr_index(gate_wr_index),
    .wr_data(gate_wr_data),
    .rd_en(rd_en),
    .rd_index(rd_index),
    .rd_data_reg(gate_data)
  );

  assign gate_type = gate_data[dispatch_pkg::GATE_TYPE_LSB +: 4];
  assign gate_bad = !gate_data[dispatch_pkg::GATE_PRESENT_BIT] ||
    !(gate_type == dispatch_pkg::GT_MASKABLE_REQUEST_PIN ||
      gate_type == dispatch_pkg::GT_TRAP ||
      gate_type == dispatch_pkg::GT_TASK);

  always_comb begin
    state_next = state_reg;
    escalate = 1'b0;
    rd_en = 1'b0;
    rd_index = take_vec;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          rd_en = 1'b1;
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (gate_bad) begin
          escalate = 1'b1;
        end else if (gate_type == dispatch_pkg::GT_TASK) begin
          state_next = ST_TASK;
        end else begin
          state_next = ST_PUSH_FLAGS;
        end
      end
      ST_PUSH_FLAGS: begin
        escalate = push_fault;
        state_next = ST_PUSH_CS;
      end
      ST_PUSH_CS: begin
        escalate = push_fault;
        state_next = ST_PUSH_IP;
      end
      ST_PUSH_IP: begin
        escalate = push_fault;
        state_next = ST_BRANCH;
      end
      ST_BRANCH: state_next = ST_IDLE;
      ST_TASK: state_next = ST_IDLE;
      ST_HALT: state_next = ST_HALT;
      default: state_next = ST_IDLE;
    endcase
    // A failure inside a double-fault dispatch cannot be recovered
    if (escalate) begin
      if (dispatch_vector == dispatch_pkg::VEC_DOUBLE) begin
        state_next = ST_HALT;
      end else begin
        rd_en = 1'b1;
        rd_index = dispatch_pkg::VEC_DOUBLE;
        state_next = ST_READ;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Faults return to the faulting instruction, traps to the next one
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dispatch_vector <= 8'h00;
      dispatch_class <= dispatch_pkg::CLS_MASKABLE_REQUEST_PIN;
      saved_cs_reg <= 16'h0000;
      saved_ip_reg <= 32'h00000000;
    end else if (state_reg == ST_IDLE && take) begin
      dispatch_vector <= take_vec;
      dispatch_class <= take_class;
      saved_cs_reg <= cur_cs;
      saved_ip_reg <= (take_class == dispatch_pkg::CLS_TRAP) ?
                      next_ip : cur_ip;
    end else if (escalate && state_next == ST_READ) begin
      dispatch_vector <= dispatch_pkg::VEC_DOUBLE;
      dispatch_class <= dispatch_pkg::CLS_ABORT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      event_ack <= 1'b0;
      flush_req <= 1'b0;
      busy <= 1'b0;
      shutdown <= 1'b0;
      task_call_valid <= 1'b0;
      task_selector <= 16'h0000;
    end else begin
      event_ack <= (state_reg == ST_IDLE) && take;
      flush_req <= ((state_reg == ST_IDLE) && take) || interrupt_return_op_take;
      busy <= state_next != ST_IDLE;
      shutdown <= state_next == ST_HALT;
      task_call_valid <= state_next == ST_TASK;
      if (state_next == ST_TASK) begin
        task_selector <= gate_data[dispatch_pkg::GATE_SEL_LSB +: 16];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      push_valid <= 1'b0;
      push_data <= 32'h00000000;
    end else begin
      push_valid <= 1'b0;
      case (state_next)
        ST_PUSH_FLAGS: begin
          push_valid <= 1'b1;
          push_data <= flags_word;
        end
        ST_PUSH_CS: begin
          push_valid <= 1'b1;
          push_data <= {16'h0000, saved_cs_reg};
        end
        ST_PUSH_IP: begin
          push_valid <= 1'b1;
          push_data <= saved_ip_reg;
        end
        default: push_data <= push_data;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      branch_valid <= 1'b0;
      branch_cs <= 16'h0000;
      branch_ip <= 32'h00000000;
    end else begin
      branch_valid <= (state_next == ST_BRANCH) || interrupt_return_op_take;
      if (state_next == ST_BRANCH) begin
        branch_cs <= gate_data[dispatch_pkg::GATE_SEL_LSB +: 16];
        branch_ip <= gate_data[dispatch_pkg::GATE_OFF_LSB +: 32];
      end else if (interrupt_return_op_take) begin
        branch_cs <= interrupt_return_op_cs;
        branch_ip <= interrupt_return_op_ip;
      end
    end
  end

  // Dispatch owns the flag in its branch cycle; a load then is dropped
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flags_word <= dispatch_pkg::FLAGS_RESET;
    end else if (state_next == ST_BRANCH) begin
      if (gate_type == dispatch_pkg::GT_MASKABLE_REQUEST_PIN) begin
        flags_word[dispatch_pkg::FLAGS_IF_BIT] <= 1'b0;
      end
    end else if (interrupt_return_op_take) begin
      flags_word <= interrupt_return_op_flags;
    end else if (flags_load) begin
      flags_word <= flags_load_data;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_push_ok;
    push_valid && !push_fault;
  endsequence

  a_maskable_request_pin_gate_if: assert property (
    branch_valid && state_reg == ST_BRANCH && gate_type == 4'he
    |-> !flags_word[9]) else $error("interrupt gate left IF set");

  a_trap_gate_if: assert property (
    state_reg == ST_PUSH_IP && !push_fault && gate_type == 4'hf
    |=> flags_word[9] == $past(flags_word[9], 1))
    else $error("trap gate changed IF");

  a_push_order: assert property (
    $rose(push_valid) && !push_fault
    |=> push_valid && push_data == {16'h0000, saved_cs_reg}
        ##0 s_push_ok ##1 push_valid && push_data == saved_ip_reg)
    else $error("push order wrong");

  a_branch_target: assert property (
    s_push_ok ##1 s_push_ok ##1 s_push_ok
    |=> branch_valid && branch_ip == gate_data[31:0] &&
        branch_cs == gate_data[47:32])
    else $error("branch target not from gate");

  a_exc_first: assert property (
    state_reg == ST_IDLE && exc_found && maskable_request_pin
    |=> event_ack && dispatch_vector == {3'h0, $past(exc_index)})
    else $error("maskable interrupt beat exception");

  a_quotient_vec: assert property (
    state_reg == ST_IDLE && quotient_fault_req
    |=> event_ack && dispatch_vector == 8'h00 &&
        dispatch_class == dispatch_pkg::CLS_FAULT)
    else $error("quotient fault not vector 0");

  a_double_fault: assert property (
    state_reg == ST_READ && gate_bad && dispatch_vector != 8'h08
    |=> dispatch_vector == 8'h08 && state_reg == ST_READ)
    else $error("bad gate did not escalate");

  a_interrupt_return_op_flags: assert property (
    interrupt_return_op_take |=> branch_valid && flush_req &&
      flags_word == $past(interrupt_return_op_flags) && branch_ip == $past(interrupt_return_op_ip))
    else $error("interrupt return did not restore");

  a_no_reserved: assert property (
    event_ack && dispatch_class != dispatch_pkg::CLS_MASKABLE_REQUEST_PIN &&
    dispatch_vector < 8'h20
    |-> dispatch_vector != 8'h0f && dispatch_vector < 8'h16)
    else $error("reserved vector dispatched");

  a_dispatch_ends: assert property (
    event_ack |-> flush_req ##[1:12]
      (branch_valid || task_call_valid || shutdown))
    else $error("dispatch did not reach handler");
endmodule

// File: tb/dispatch_partner.sv
// Far side: the stack writer behind the push port, and the log of what
// reached the stack. It fails a push only when the bench arms it.
module dispatch_partner (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic push_valid,
  input wire logic [31:0] push_data,
  input wire logic fault_cmd,
  output logic push_fault,
  output logic [95:0] push_log
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed_reg;
  // Answer in the push cycle itself, one failed push per arming
  assign push_fault = push_valid & armed_reg;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) armed_reg <= 1'h0;
    else if (fault_cmd) armed_reg <= 1'h1;
    else if (push_fault) armed_reg <= 1'h0;
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) push_log <= '0;
    else if (push_valid && !push_fault) begin
      push_log <= {push_log[63:0], push_data};
    end
  end
endmodule

// File: tb/test_interrupt_exception_dispatch.sv
module test_interrupt_exception_dispatch;
  timeunit 1ns;
  timeprecision 1ps;
  typedef dispatch_pkg::event_class_t cls_t;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [17:0] req = '0;
  logic math_unit_absent = 1'h1;
  logic branch_tracking_en = 1'h0;
  logic indirect_target = 1'h0;
  logic target_is_marker = 1'h0;
  logic nmi_req = 1'h0;
  logic maskable_request_pin = 1'h0;
  logic swint_req = 1'h0;
  logic flags_load = 1'h0;
  logic interrupt_return_op_req = 1'h0;
  logic gate_wr_en = 1'h0;
  logic fault_cmd = 1'h0;
  logic [7:0] maskable_vector = '0;
  logic [7:0] swint_vector = '0;
  logic [7:0] gate_wr_index = '0;
  logic [15:0] cur_cs = 16'h0123;
  logic [15:0] interrupt_return_op_cs = '0;
  logic [31:0] cur_ip = 32'h0000a000;
  logic [31:0] next_ip;
  logic [31:0] flags_load_data = '0;
  logic [31:0] interrupt_return_op_ip = '0;
  logic [31:0] interrupt_return_op_flags = '0;
  logic [63:0] gate_wr_data = '0;
  logic event_ack, flush_req, busy, push_valid, push_fault;
  logic branch_valid, task_call_valid, shutdown;
  logic [7:0] dispatch_vector;
  cls_t dispatch_class;
  logic [15:0] branch_cs, task_selector;
  logic [31:0] push_data, branch_ip, flags_word;
  logic [95:0] push_log;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [7:0] VT [18] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h14, 8'h15};
  assign next_ip = cur_ip + 32'h00000004;

  interrupt_exception_dispatch DUT (
    .ref_clk, .reset_n,
    .quotient_fault_req(req[0]), .debug_event_req(req[1]),
    .breakpoint_trap_req(req[2]), .overflow_trap_req(req[3]),
    .bound_range_fault_req(req[4]), .invalid_opcode_req(req[5]),
    .fp_or_wait_op(req[6]), .math_unit_absent,
    .invalid_task_state_req(req[7]), .segment_not_present_req(req[8]),
    .stack_fault_req(req[9]), .general_protection_req(req[10]),
    .page_fault_req(req[11]), .math_fault_req(req[12]),
    .alignment_check_req(req[13]), .machine_check_req(req[14]),
    .vector_fp_exception_req(req[15]),
    .virtualization_exception_req(req[16]),
    .checked_return_fail(req[17]), .branch_tracking_en, .indirect_target,
    .target_is_marker, .nmi_req, .maskable_request_pin, .maskable_vector,
    .swint_req, .swint_vector, .cur_cs, .cur_ip, .next_ip, .push_fault,
    .flags_load, .flags_load_data, .interrupt_return_op_req, .interrupt_return_op_cs, .interrupt_return_op_ip,
    .interrupt_return_op_flags, .gate_wr_en, .gate_wr_index, .gate_wr_data, .event_ack,
    .flush_req, .busy, .dispatch_vector, .dispatch_class, .push_valid,
    .push_data, .branch_valid, .branch_cs, .branch_ip, .task_call_valid,
    .task_selector, .flags_word, .shutdown
  );
  dispatch_partner far_side (
    .ref_clk, .reset_n, .push_valid, .push_data, .fault_cmd, .push_fault,
    .push_log
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Whole run needs under 1500 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [95:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [63:0] gate(input logic [7:0] v, a);
    return {8'h00, a, 8'h10, v, 24'h100000, v};
  endfunction
  function automatic cls_t cls_of_vec(input logic [7:0] v);
    if (v == 8'h12) return dispatch_pkg::CLS_ABORT;
    if (v == 8'h01 || v == 8'h03 || v == 8'h04) return dispatch_pkg::CLS_TRAP;
    return dispatch_pkg::CLS_FAULT;
  endfunction
  task automatic fire_req(input int i);
    @(posedge ref_clk);
    req <= 18'h00001 << i;
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic fire_sw(input logic [7:0] v);
    @(posedge ref_clk);
    swint_req <= 1'h1;
    swint_vector <= v;
    @(posedge ref_clk);
    swint_req <= 1'h0;
  endtask
  task automatic quiet(input int n);
    #1;
    repeat (n) begin
      check(event_ack, 1'h0, "unexpected take");
      tick();
    end
  endtask
  // Mode 0 full walk, 1 task gate, 2 escalated walk, 3 ends in shutdown
  task automatic run(input logic [7:0] v, input cls_t c,
                     input logic [31:0] ip, fpre, fpost, input int mode);
    int n;
    n = 0;
    #1;
    while (event_ack !== 1'h1 && n < 10) begin
      tick();
      n++;
    end
    check({event_ack, flush_req, busy}, 3'h7, "ack and flush");
    n = 0;
    while (branch_valid !== 1'h1 && task_call_valid !== 1'h1 &&
           shutdown !== 1'h1 && n < 40) begin
      tick();
      n++;
    end
    check(dispatch_vector, v, "vector");
    check(dispatch_class, c, "class");
    if (mode == 1) begin
      check({task_call_valid, task_selector}, {1'h1, 8'h10, v}, "task");
    end else if (mode != 3) begin
      check(branch_valid, 1'h1, "branch");
      check({branch_cs, branch_ip}, gate(v, 8'h00), "target");
      check(flags_word, fpost, "flags");
      check(push_log[95:32], {fpre, 16'h0000, cur_cs}, "pushes");
      if (mode == 0) check(push_log[31:0], ip, "pushed ip");
    end
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'h1;
    #1;
    check({event_ack, flush_req, busy, push_valid, branch_valid,
           task_call_valid, shutdown, dispatch_vector, dispatch_class},
          '0, "reset outputs");
    check(flags_word, 32'h00000002, "reset flags");
    for (int i = 0; i < 256; i++) begin
      @(posedge ref_clk);
      gate_wr_en <= 1'h1;
      gate_wr_index <= i[7:0];
      gate_wr_data <= gate(i[7:0], i == 8'h40 ? 8'h8e : i == 8'h50 ?
                           8'h85 : i == 8'h60 ? 8'h0f : 8'h8f);
    end
    @(posedge ref_clk);
    gate_wr_en <= 1'h0;
    flags_load <= 1'h1;
    flags_load_data <= 32'h00000202;
    @(posedge ref_clk);
    flags_load <= 1'h0;
    for (int i = 0; i < 18; i++) begin
      @(posedge ref_clk);
      cur_ip <= 32'h0000a000 + 32'(i * 16);
      fire_req(i);
      run(VT[i], cls_of_vec(VT[i]), cls_of_vec(VT[i]) ==
          dispatch_pkg::CLS_TRAP ? next_ip : cur_ip, 32'h00000202,
          32'h00000202, 0);
    end
    @(posedge ref_clk);
    math_unit_absent <= 1'h0;
    fire_req(6);
    quiet(4);
    @(posedge ref_clk);
    math_unit_absent <= 1'h1;
    branch_tracking_en <= 1'h1;
    indirect_target <= 1'h1;
    target_is_marker <= 1'h1;
    quiet(4);
    @(posedge ref_clk);
    target_is_marker <= 1'h0;
    @(posedge ref_clk);
    branch_tracking_en <= 1'h0;
    run(8'h15, dispatch_pkg::CLS_FAULT, cur_ip, 32'h00000202, 32'h00000202,
        0);
    @(posedge ref_clk);
    nmi_req <= 1'h1;
    @(posedge ref_clk);
    nmi_req <= 1'h0;
    run(8'h02, dispatch_pkg::CLS_MASKABLE_REQUEST_PIN, cur_ip, 32'h00000202, 32'h00000202, 0);
    fire_sw(8'h40);
    run(8'h40, dispatch_pkg::CLS_TRAP, next_ip, 32'h00000202, 32'h00000002,
        0);
    @(posedge ref_clk);
    maskable_request_pin <= 1'h1;
    maskable_vector <= 8'h30;
    quiet(4);
    @(posedge ref_clk);
    maskable_request_pin <= 1'h0;
    interrupt_return_op_req <= 1'h1;
    interrupt_return_op_cs <= 16'h0456;
    interrupt_return_op_ip <= 32'h0000b000;
    interrupt_return_op_flags <= 32'h00000202;
    @(posedge ref_clk);
    interrupt_return_op_req <= 1'h0;
    #1;
    check({branch_valid, flush_req, branch_cs, branch_ip, flags_word},
          {2'h3, 16'h0456, 32'h0000b000, 32'h00000202}, "interrupt_return_op");
    @(posedge ref_clk);
    maskable_request_pin <= 1'h1;
    maskable_vector <= 8'h10;
    quiet(4);
    @(posedge ref_clk);
    maskable_vector <= 8'h30;
    @(posedge ref_clk);
    maskable_request_pin <= 1'h0;
    run(8'h30, dispatch_pkg::CLS_MASKABLE_REQUEST_PIN, cur_ip, 32'h00000202, 32'h00000202,
        0);
    @(posedge ref_clk);
    req <= 18'h00c00;
    maskable_request_pin <= 1'h1;
    swint_req <= 1'h1;
    @(posedge ref_clk);
    req <= '0;
    maskable_request_pin <= 1'h0;
    swint_req <= 1'h0;
    run(8'h0d, dispatch_pkg::CLS_FAULT, cur_ip, 32'h00000202, 32'h00000202,
        0);
    fire_sw(8'h50);
    run(8'h50, dispatch_pkg::CLS_TRAP, '0, '0, '0, 1);
    @(posedge ref_clk);
    fault_cmd <= 1'h1;
    @(posedge ref_clk);
    fault_cmd <= 1'h0;
    fire_sw(8'h41);
    run(8'h08, dispatch_pkg::CLS_ABORT, '0, 32'h00000202, 32'h00000202,
        2);
    fire_sw(8'h60);
    run(8'h08, dispatch_pkg::CLS_ABORT, '0, 32'h00000202, 32'h00000202,
        2);
    @(posedge ref_clk);
    gate_wr_en <= 1'h1;
    gate_wr_index <= 8'h08;
    gate_wr_data <= gate(8'h08, 8'h0f);
    @(posedge ref_clk);
    gate_wr_en <= 1'h0;
    fire_sw(8'h60);
    run(8'h08, dispatch_pkg::CLS_ABORT, '0, '0, '0, 3);
    check(shutdown, 1'h1, "shutdown");
    fire_req(0);
    quiet(4);
    @(posedge ref_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'h1;
    #1;
    check({shutdown, busy}, 2'h0, "shutdown cleared");
    summarize();
  end
endmodule
